// File: hw/pfcc_pkg.sv
package pfcc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DEB_TIME_US = 1000;
  localparam int unsigned DEB_CYCLES = (DEB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_SENSE = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hC;

  // Control register fields and reset value
  localparam int unsigned CTRL_LIFT_EN = 0;
  localparam int unsigned CTRL_LINK_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // Event bits of the status and mask registers
  localparam int unsigned EV_UP_TOP = 0;
  localparam int unsigned EV_LO_TOP = 1;
  localparam int unsigned EV_UP_EMPTY = 2;
  localparam int unsigned EV_LO_EMPTY = 3;
  localparam int unsigned EV_FRAME = 4;
  localparam int unsigned EV_CHOSEN = 5;
  localparam int unsigned EV_W = 6;

  // Link frame layout
  localparam int unsigned TX_W = 16;
  localparam int unsigned RX_W = 8;
  localparam int unsigned CMD_FEED_RUN = 0;
  localparam int unsigned CMD_FEED_UPPER = 1;
  localparam logic [3:0] LAST_BIT = 4'hF;

  // Select code that addresses this feeder at ports 1,2,3
  localparam logic [2:0] SEL_ME = 3'h1;

  // Lift state of one cassette
  typedef enum logic [1:0] {
    LIFT_IDLE = 2'b00,
    LIFT_RUN = 2'b01,
    LIFT_TOP = 2'b10
  } pfcc_lift_t;

  // Decoded paper size
  typedef enum logic [2:0] {
    SIZE_LEDGER = 3'b000,
    SIZE_A3 = 3'b001,
    SIZE_B4 = 3'b010,
    SIZE_LEGAL = 3'b011,
    SIZE_B5 = 3'b100,
    SIZE_LETTER = 3'b101,
    SIZE_A4A5 = 3'b110,
    SIZE_NONE = 3'b111
  } pfcc_size_t;

  // Remaining paper, 25/50/75/100 percent
  typedef enum logic [1:0] {
    LVL_25 = 2'b00,
    LVL_50 = 2'b01,
    LVL_75 = 2'b10,
    LVL_100 = 2'b11
  } pfcc_level_t;

  // Sensor group of one cassette, all raw pin levels
  typedef struct packed {
    logic cassette_sw_n;
    logic lift_limit_n;
    logic paper_present_n;
    logic size_sense_a;
    logic size_sense_b;
    logic size_sense_c;
    logic level_bit_a;
    logic level_bit_b;
  } pfcc_sense_t;

  localparam int unsigned SENSE_W = $bits(pfcc_sense_t);

endpackage

// File: hw/pfcc_debounce.sv
`timescale 1ns/1ps
module pfcc_debounce #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned COUNT = 125000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] raw_i,
  output logic [WIDTH-1:0] clean_o
);

  localparam int unsigned CW = $clog2(COUNT + 1);

  // Refuse settings the counter cannot serve
  initial begin
    if (COUNT < 1 || WIDTH < 1) begin
      $error("pfcc_debounce: COUNT and WIDTH must be at least 1");
    end
  end

  // Whole state of the filter
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3; // Copy of s2 one cycle older, compared against s2 to spot bouncing
    logic [CW-1:0] cnt;
    logic [WIDTH-1:0] clean;
  } pfcc_deb_state_t;

  pfcc_deb_state_t q_ff;
  pfcc_deb_state_t nxt_q;

  // Group filter: any change restarts the wait, a steady vector is taken
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = raw_i;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    if (q_ff.s2 == q_ff.clean) begin
      // Nothing pending
      nxt_q.cnt = '0;
    end else if (q_ff.s2 != q_ff.s3) begin
      // Still bouncing
      nxt_q.cnt = '0;
    end else if (q_ff.cnt == CW'(COUNT - 1)) begin
      // Stable long enough
      nxt_q.clean = q_ff.s2;
      nxt_q.cnt = '0;
    end else begin
      nxt_q.cnt = q_ff.cnt + 1'b1;
    end
  end

  // Register the state; inputs idle high
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '{s1: '1, s2: '1, s3: '1, cnt: '0, clean: '1};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign clean_o = q_ff.clean;

endmodule // pfcc_debounce

// File: hw/pfcc_top.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module pfcc_top #(
  parameter int unsigned DEB_CYCLES = pfcc_pkg::DEB_CYCLES
) (
  // Clock and supply monitor reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Cassette sensors
  input wire pfcc_pkg::pfcc_sense_t upper_i,
  input wire pfcc_pkg::pfcc_sense_t lower_i,
  // Motors and empty flags
  output logic upper_lift_motor_o,
  output logic lower_lift_motor_o,
  output logic feed_motor_run_o,
  output logic feed_motor_upper_o,
  output logic upper_empty_o,
  output logic lower_empty_o,
  // Feeder select bus, ports 1..3 and onward copy
  input wire logic [2:0] feeder_pick_line_i,
  output logic [2:0] feeder_pick_next_o,
  output logic unit_chosen_n_o,
  // Serial link to host
  input wire logic link_clk_n_i,
  input wire logic link_rx_line_i,
  output logic link_tx_line_o,
  output logic link_tx_oe_n_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);

  // Refuse a filter time the logic cannot count
  initial begin
    if (DEB_CYCLES < 1) begin
      $error("pfcc_top: DEB_CYCLES must be at least 1");
    end
  end

  // Whole state of the block
  typedef struct packed {
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic rx_s1;
    logic rx_s2;
    pfcc_pkg::pfcc_lift_t up_st;
    pfcc_pkg::pfcc_lift_t lo_st;
    logic up_motor;
    logic lo_motor;
    logic up_empty;
    logic lo_empty;
    pfcc_pkg::pfcc_size_t up_size;
    pfcc_pkg::pfcc_size_t lo_size;
    pfcc_pkg::pfcc_level_t up_lvl;
    pfcc_pkg::pfcc_level_t lo_lvl;
    logic [3:0] bit_cnt;
    logic [pfcc_pkg::TX_W-1:0] tx_sh;
    logic [pfcc_pkg::RX_W-1:0] rx_sh;
    logic [pfcc_pkg::RX_W-1:0] cmd;
    logic feed_run;
    logic feed_upper;
    logic chosen_n;
    logic [2:0] pick_next;
    logic tx_line;
    logic tx_oe_n;
    logic [pfcc_pkg::EV_W-1:0] status;
    logic [pfcc_pkg::EV_W-1:0] mask;
    logic [1:0] ctrl;
    logic [31:0] rd_data;
    logic irq;
  } pfcc_top_state_t;

  logic [1:0] rst_sync_ff; // Reset release chain
  logic rst_n; // Reset used by all logic except the release chain
  pfcc_top_state_t q_ff;
  pfcc_top_state_t nxt_q;
  logic [2*pfcc_pkg::SENSE_W-1:0] deb_out; // Filtered sensor levels
  pfcc_pkg::pfcc_sense_t up_s; // Clean upper sensors
  pfcc_pkg::pfcc_sense_t lo_s; // Clean lower sensors

  // Supply monitor reset, released through two flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Sensors pass a synchroniser and a settle filter
  pfcc_debounce #(
    .WIDTH(2 * pfcc_pkg::SENSE_W),
    .COUNT(DEB_CYCLES)
  ) u_deb (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .raw_i({upper_i, lower_i}),
    .clean_o(deb_out)
  );
  assign up_s = deb_out[2*pfcc_pkg::SENSE_W-1:pfcc_pkg::SENSE_W];
  assign lo_s = deb_out[pfcc_pkg::SENSE_W-1:0];

  // Next lift state of one cassette
  function automatic pfcc_pkg::pfcc_lift_t lift_next(input pfcc_pkg::pfcc_lift_t st, input logic en,
                                                     input pfcc_pkg::pfcc_sense_t s);
    pfcc_pkg::pfcc_lift_t r;
    r = pfcc_pkg::LIFT_IDLE;
    if (!s.cassette_sw_n && en) begin
      unique case (st)
        pfcc_pkg::LIFT_IDLE: r = pfcc_pkg::LIFT_RUN;
        pfcc_pkg::LIFT_RUN: r = s.lift_limit_n ? pfcc_pkg::LIFT_RUN : pfcc_pkg::LIFT_TOP;
        pfcc_pkg::LIFT_TOP: r = s.lift_limit_n ? pfcc_pkg::LIFT_RUN : pfcc_pkg::LIFT_TOP;
        default: r = pfcc_pkg::LIFT_IDLE;
      endcase
    end
    return r;
  endfunction

  // Size from sensors a, b, c
  function automatic pfcc_pkg::pfcc_size_t size_of(input pfcc_pkg::pfcc_sense_t s);
    pfcc_pkg::pfcc_size_t r;
    unique case ({s.size_sense_a, s.size_sense_b, s.size_sense_c})
      3'h4: r = pfcc_pkg::SIZE_LEDGER;
      3'h0: r = pfcc_pkg::SIZE_A3;
      3'h7: r = pfcc_pkg::SIZE_B4;
      3'h6: r = pfcc_pkg::SIZE_LEGAL;
      3'h5: r = pfcc_pkg::SIZE_B5;
      3'h1: r = pfcc_pkg::SIZE_LETTER;
      3'h2: r = pfcc_pkg::SIZE_A4A5;
      3'h3: r = pfcc_pkg::SIZE_NONE;
    endcase
    return r;
  endfunction

  // Remaining paper from the two level bits
  function automatic pfcc_pkg::pfcc_level_t level_of(input pfcc_pkg::pfcc_sense_t s);
    pfcc_pkg::pfcc_level_t r;
    unique case ({s.level_bit_a, s.level_bit_b})
      2'h0: r = pfcc_pkg::LVL_25;
      2'h1: r = pfcc_pkg::LVL_50;
      2'h3: r = pfcc_pkg::LVL_75;
      2'h2: r = pfcc_pkg::LVL_100;
    endcase
    return r;
  endfunction

  // Main next-state logic
  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic frame_done;
    logic [pfcc_pkg::EV_W-1:0] ev;
    logic [pfcc_pkg::EV_W-1:0] clr;
    logic [pfcc_pkg::TX_W-1:0] answer;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    frame_done = 1'b0;
    ev = '0;
    clr = '0;
    answer = '0;
    nxt_q = q_ff;

    // Two-flop synchronisers for select bus and link
    nxt_q.sel_s1 = feeder_pick_line_i;
    nxt_q.sel_s2 = q_ff.sel_s1;
    nxt_q.sck_s1 = link_clk_n_i;
    nxt_q.sck_s2 = q_ff.sck_s1;
    nxt_q.sck_s3 = q_ff.sck_s2;
    nxt_q.rx_s1 = link_rx_line_i;
    nxt_q.rx_s2 = q_ff.rx_s1;

    // Link clock is active low: rising edge ends a bit
    sck_rise = q_ff.sck_s2 && !q_ff.sck_s3;
    sck_fall = !q_ff.sck_s2 && q_ff.sck_s3;

    // Select decode and rotated copy for the next feeder
    nxt_q.chosen_n = (q_ff.sel_s2 != pfcc_pkg::SEL_ME);
    nxt_q.pick_next = {q_ff.sel_s2[0], q_ff.sel_s2[2], q_ff.sel_s2[1]};

    // Cassette lifting and empty detection
    nxt_q.up_st = lift_next(q_ff.up_st, q_ff.ctrl[pfcc_pkg::CTRL_LIFT_EN], up_s);
    nxt_q.lo_st = lift_next(q_ff.lo_st, q_ff.ctrl[pfcc_pkg::CTRL_LIFT_EN], lo_s);
    nxt_q.up_motor = (nxt_q.up_st == pfcc_pkg::LIFT_RUN);
    nxt_q.lo_motor = (nxt_q.lo_st == pfcc_pkg::LIFT_RUN);
    // Empty only while the plate is held at top, so a pulled cassette never reports empty
    nxt_q.up_empty = (nxt_q.up_st == pfcc_pkg::LIFT_TOP) && up_s.paper_present_n;
    nxt_q.lo_empty = (nxt_q.lo_st == pfcc_pkg::LIFT_TOP) && lo_s.paper_present_n;
    nxt_q.up_size = size_of(up_s);
    nxt_q.lo_size = size_of(lo_s);
    nxt_q.up_lvl = level_of(up_s);
    nxt_q.lo_lvl = level_of(lo_s);

    // Answer word: levels, sizes, empty, present, at top
    answer = {q_ff.up_lvl, q_ff.lo_lvl, q_ff.up_size, q_ff.lo_size, q_ff.up_empty, q_ff.lo_empty,
              !up_s.cassette_sw_n, !lo_s.cassette_sw_n,
              q_ff.up_st == pfcc_pkg::LIFT_TOP, q_ff.lo_st == pfcc_pkg::LIFT_TOP};

    // Serial frame: 16 bits out, first 8 bits in
    if (q_ff.chosen_n || !q_ff.ctrl[pfcc_pkg::CTRL_LINK_EN]) begin
      nxt_q.bit_cnt = '0;
      nxt_q.tx_sh = answer;
      nxt_q.tx_oe_n = 1'b1;
      nxt_q.tx_line = 1'b1;
    end else begin
      nxt_q.tx_oe_n = 1'b0;
      nxt_q.tx_line = q_ff.tx_sh[pfcc_pkg::TX_W-1];
      if (sck_rise) begin
        nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
        if (q_ff.bit_cnt < 4'(pfcc_pkg::RX_W)) begin
          nxt_q.rx_sh = {q_ff.rx_sh[pfcc_pkg::RX_W-2:0], q_ff.rx_s2};
        end
        if (q_ff.bit_cnt == pfcc_pkg::LAST_BIT) begin
          frame_done = 1'b1;
          nxt_q.tx_sh = answer;
        end else begin
          nxt_q.tx_sh = {q_ff.tx_sh[pfcc_pkg::TX_W-2:0], 1'b0};
        end
      end
    end

    // Host command drives the feed motor
    if (frame_done) begin
      nxt_q.cmd = q_ff.rx_sh;
      nxt_q.feed_run = q_ff.rx_sh[pfcc_pkg::CMD_FEED_RUN];
      nxt_q.feed_upper = q_ff.rx_sh[pfcc_pkg::CMD_FEED_UPPER];
    end

    // Events
    ev[pfcc_pkg::EV_UP_TOP] = (nxt_q.up_st == pfcc_pkg::LIFT_TOP) && (q_ff.up_st != pfcc_pkg::LIFT_TOP);
    ev[pfcc_pkg::EV_LO_TOP] = (nxt_q.lo_st == pfcc_pkg::LIFT_TOP) && (q_ff.lo_st != pfcc_pkg::LIFT_TOP);
    ev[pfcc_pkg::EV_UP_EMPTY] = nxt_q.up_empty && !q_ff.up_empty;
    ev[pfcc_pkg::EV_LO_EMPTY] = nxt_q.lo_empty && !q_ff.lo_empty;
    ev[pfcc_pkg::EV_FRAME] = frame_done;
    ev[pfcc_pkg::EV_CHOSEN] = !nxt_q.chosen_n && q_ff.chosen_n;

    // Register reads; status clears the bits it returned
    nxt_q.rd_data = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        pfcc_pkg::ADDR_STATUS: begin
          nxt_q.rd_data = 32'(q_ff.status);
          clr = q_ff.status;
        end
        pfcc_pkg::ADDR_MASK: nxt_q.rd_data = 32'(q_ff.mask);
        pfcc_pkg::ADDR_SENSE: nxt_q.rd_data = {12'h000, q_ff.cmd, q_ff.rx_sh[0], q_ff.feed_run,
                                               q_ff.feed_upper, q_ff.chosen_n, q_ff.up_st, q_ff.lo_st,
                                               q_ff.up_motor, q_ff.lo_motor, q_ff.up_empty, q_ff.lo_empty};
        pfcc_pkg::ADDR_CTRL: nxt_q.rd_data = 32'(q_ff.ctrl);
        default: nxt_q.rd_data = '0;
      endcase
    end

    // Register writes
    if (reg_wr_i) begin
      if (reg_addr_i == pfcc_pkg::ADDR_MASK) begin
        nxt_q.mask = reg_wdata_i[pfcc_pkg::EV_W-1:0];
      end
      if (reg_addr_i == pfcc_pkg::ADDR_CTRL) begin
        nxt_q.ctrl = reg_wdata_i[1:0];
      end
    end

    // Sticky status, set wins over clear; level interrupt
    nxt_q.status = (q_ff.status & ~clr) | ev;
    nxt_q.irq = |(nxt_q.status & nxt_q.mask);
  end

  // Register the state
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
      q_ff.sel_s1 <= 3'h0;
      q_ff.sck_s1 <= 1'b1;
      q_ff.sck_s2 <= 1'b1;
      q_ff.sck_s3 <= 1'b1;
      q_ff.chosen_n <= 1'b1;
      q_ff.tx_line <= 1'b1;
      q_ff.tx_oe_n <= 1'b1;
      q_ff.ctrl <= pfcc_pkg::CTRL_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from flops
  assign upper_lift_motor_o = q_ff.up_motor;
  assign lower_lift_motor_o = q_ff.lo_motor;
  assign feed_motor_run_o = q_ff.feed_run;
  assign feed_motor_upper_o = q_ff.feed_upper;
  assign upper_empty_o = q_ff.up_empty;
  assign lower_empty_o = q_ff.lo_empty;
  assign feeder_pick_next_o = q_ff.pick_next;
  assign unit_chosen_n_o = q_ff.chosen_n;
  assign link_tx_line_o = q_ff.tx_line;
  assign link_tx_oe_n_o = q_ff.tx_oe_n;
  assign reg_rdata_o = q_ff.rd_data;
  assign irq_o = q_ff.irq;

  // Checks
  a_lift_start_up: assert property (@(posedge clock_i) disable iff (!rst_n)
    (q_ff.up_st == pfcc_pkg::LIFT_IDLE && !up_s.cassette_sw_n && q_ff.ctrl[0]) |=> upper_lift_motor_o)
    else $error("upper lift did not start on insertion");
  a_lift_stop_up: assert property (@(posedge clock_i) disable iff (!rst_n)
    (upper_lift_motor_o && !up_s.lift_limit_n) |=> !upper_lift_motor_o)
    else $error("upper lift kept running at top");
  a_empty_flag_lo: assert property (@(posedge clock_i) disable iff (!rst_n)
    (q_ff.lo_st == pfcc_pkg::LIFT_TOP && !lo_s.lift_limit_n && !lo_s.cassette_sw_n && q_ff.ctrl[0] &&
     lo_s.paper_present_n) |=> lower_empty_o)
    else $error("lower empty not reported");
  a_relift_lo: assert property (@(posedge clock_i) disable iff (!rst_n)
    (q_ff.lo_st == pfcc_pkg::LIFT_TOP && lo_s.lift_limit_n && !lo_s.cassette_sw_n && q_ff.ctrl[0])
    |=> lower_lift_motor_o ##1 q_ff.lo_st == pfcc_pkg::LIFT_RUN)
    else $error("lower lift did not restart");
  a_feed_cmd: assert property (@(posedge clock_i) disable iff (!rst_n)
    $rose(q_ff.status[pfcc_pkg::EV_FRAME]) |-> feed_motor_run_o == q_ff.cmd[0] && feed_motor_upper_o == q_ff.cmd[1])
    else $error("feed motor does not follow command");
  a_size_ledger: assert property (@(posedge clock_i) disable iff (!rst_n)
    ({up_s.size_sense_a, up_s.size_sense_b, up_s.size_sense_c} == 3'h4) |=> q_ff.up_size == pfcc_pkg::SIZE_LEDGER)
    else $error("ledger size misdecoded");
  a_level_half: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!lo_s.level_bit_a && lo_s.level_bit_b) |=> q_ff.lo_lvl == pfcc_pkg::LVL_50)
    else $error("fifty percent level misdecoded");
  a_select_me: assert property (@(posedge clock_i) disable iff (!rst_n)
    (q_ff.sel_s2 == 3'h1) |=> !unit_chosen_n_o ##1 $past(feeder_pick_next_o, 1) == 3'h4)
    else $error("select decode or onward copy wrong");
  a_tx_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
    unit_chosen_n_o |=> link_tx_oe_n_o)
    else $error("link driven while not chosen");

endmodule // pfcc_top

// File: test/pfcc_host_model.sv
`timescale 1ns/1ps
module pfcc_host_model (
  // Feeder select bus toward the feeders
  output logic [2:0] feeder_pick_line_o,
  // Serial link, one line per direction and a shared clock
  output logic link_clk_n_o,
  output logic link_rx_line_o,
  input wire logic link_tx_line_i,
  input wire logic link_tx_oe_n_i
);
  localparam int HALF_NS = 80; // Half of the 160 ns link period
  logic answered; // High when some feeder drove the reply line in the last frame

  // Idle levels before the first designation
  initial begin
    feeder_pick_line_o = 3'h0;
    link_clk_n_o = 1'b1; // Link clock rests high outside frames
    link_rx_line_o = 1'b1;
    answered = 1'b0;
  end

  // Put one designation code on the select lines, then give the feeders time to decode
  task automatic pick(input logic [2:0] code);
    feeder_pick_line_o = code;
    #(5 * HALF_NS);
  endtask

  // Clock one 16-bit frame: command out MSB first, reply taken at each rising edge
  task automatic frame(input logic [7:0] cmd, output logic [15:0] got);
    got = 16'h0;
    answered = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_clk_n_o = 1'b0; // Active low shared clock
      // Command in the first eight bits, a changing pattern after them
      if (i >= 8) begin
        link_rx_line_o = cmd[i-8];
      end else begin
        link_rx_line_o = ~link_rx_line_o;
      end
      #HALF_NS;
      link_clk_n_o = 1'b1;
      // A released reply line is pulled high
      got[i] = link_tx_oe_n_i ? 1'b1 : link_tx_line_i;
      answered = answered | ~link_tx_oe_n_i; // No driver at all means no such source
      #HALF_NS;
    end
    link_rx_line_o = ~link_rx_line_o; // Released data line does not keep its last value
  endtask
endmodule // pfcc_host_model

// File: test/pfcc_top_test.sv
`timescale 1ns/1ps
module pfcc_top_test;
  localparam int unsigned DEB = 4; // Short debounce for simulation
  localparam int SZ_TAB [8] = '{1, 5, 6, 7, 0, 4, 3, 2}; // Size code indexed by sensors a,b,c
  // Clock, reset and sensor groups
  logic clock_i;
  logic arst_n_i;
  pfcc_pkg::pfcc_sense_t up_s;
  pfcc_pkg::pfcc_sense_t lo_s;
  // Motor and status outputs
  logic up_motor, lo_motor, feed_run, feed_up, up_empty, lo_empty;
  // Select bus and link
  logic [2:0] pick, pick_next;
  logic chosen_n, link_clk_n, link_rx, tx, tx_oe_n;
  // Register port
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic wr, rd, irq;
  logic [15:0] got;
  int bad_count, checks;

  pfcc_top #(.DEB_CYCLES(DEB)) pfcc_top_i (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .upper_i(up_s), .lower_i(lo_s),
    .upper_lift_motor_o(up_motor), .lower_lift_motor_o(lo_motor),
    .feed_motor_run_o(feed_run), .feed_motor_upper_o(feed_up),
    .upper_empty_o(up_empty), .lower_empty_o(lo_empty),
    .feeder_pick_line_i(pick), .feeder_pick_next_o(pick_next), .unit_chosen_n_o(chosen_n),
    .link_clk_n_i(link_clk_n), .link_rx_line_i(link_rx), .link_tx_line_o(tx), .link_tx_oe_n_o(tx_oe_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq)
  );

  pfcc_host_model pfcc_host_model_i (
    .feeder_pick_line_o(pick), .link_clk_n_o(link_clk_n), .link_rx_line_o(link_rx),
    .link_tx_line_i(tx), .link_tx_oe_n_i(tx_oe_n)
  );

  // 125 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Level code from the two level bits {a,b}
  function automatic logic [1:0] lvl(input logic [1:0] ab);
    return {ab[1], ab[1] ^ ab[0]};
  endfunction

  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Present new sensor levels at a rising edge and let the filter settle
  task automatic put(input logic [7:0] u, input logic [7:0] l);
    @(posedge clock_i);
    up_s <= u;
    lo_s <= l;
    repeat (DEB + 20) @(posedge clock_i);
    #1;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #300000;
    bad_count++;
    $display("BAD watchdog expected finish seen timeout");
    wrap_up();
  end

  // Main sequence
  initial begin
    bad_count = 0;
    checks = 0;
    arst_n_i = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    up_s = 8'hFF; // No cassettes, all switches open
    lo_s = 8'hFF;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    // Reset values, mask access and an unmapped place
    chk("irq", 32'h0, 32'(irq));
    chk("chosen_n", 32'h1, 32'(chosen_n));
    rd_reg(pfcc_pkg::ADDR_CTRL, rv);
    chk("ctrl", 32'(pfcc_pkg::CTRL_RST), rv);
    rd_reg(4'h2, rv);
    chk("unmapped", 32'h0, rv);
    wr_reg(pfcc_pkg::ADDR_MASK, 32'h5);
    rd_reg(pfcc_pkg::ADDR_MASK, rv);
    chk("mask", 32'h5, rv);
    end_test("reset");
    // Lift: insert empty cassette, reach top, lose top, refill
    // Both cassettes go through the same steps
    put({1'b0, 1'b1, 1'b1, 3'h4, 2'h0}, {1'b0, 1'b1, 1'b1, 3'h4, 2'h0});
    chk("lift start", 32'h1, 32'(up_motor));
    chk("lower lift start", 32'h1, 32'(lo_motor));
    put({1'b0, 1'b0, 1'b1, 3'h4, 2'h0}, {1'b0, 1'b0, 1'b1, 3'h4, 2'h0});
    chk("lift stop", 32'h0, 32'(up_motor));
    chk("empty", 32'h1, 32'(up_empty));
    chk("lower empty", 32'h1, 32'(lo_empty));
    chk("irq raised", 32'h1, 32'(irq));
    rd_reg(pfcc_pkg::ADDR_STATUS, rv);
    chk("status", 32'hF, rv);
    repeat (2) @(posedge clock_i);
    #1 chk("irq cleared", 32'h0, 32'(irq));
    put({1'b0, 1'b1, 1'b0, 3'h4, 2'h0}, {1'b0, 1'b1, 1'b0, 3'h4, 2'h0});
    chk("relift", 32'h1, 32'(up_motor));
    chk("lower relift", 32'h1, 32'(lo_motor));
    put({1'b0, 1'b0, 1'b0, 3'h4, 2'h0}, {1'b0, 1'b0, 1'b0, 3'h4, 2'h0});
    chk("lift stop full", 32'h0, 32'(up_motor));
    chk("not empty", 32'h0, 32'(up_empty));
    rd_reg(pfcc_pkg::ADDR_STATUS, rv);
    chk("status top again", 32'h3, rv);
    rd_reg(pfcc_pkg::ADDR_SENSE, rv);
    chk("sense", 32'h1A0, rv);
    end_test("lift");
    // Every select code, decoded and passed on
    for (int i = 0; i < 8; i++) begin
      pfcc_host_model_i.pick(i[2:0]);
      chk("chosen_n", 32'(i != 1), 32'(chosen_n));
      chk("pick_next", 32'({i[0], i[2], i[1]}), 32'(pick_next));
    end
    end_test("select");
    // A frame for a code that no feeder answers
    pfcc_host_model_i.pick(3'h2);
    pfcc_host_model_i.frame(8'h01, got);
    chk("silent reply", 32'hFFFF, 32'(got));
    chk("answered", 32'h0, 32'(pfcc_host_model_i.answered));
    chk("feed ignored", 32'h0, 32'(feed_run));
    end_test("unselected");
    // Chosen: every size and level, every feed command
    pfcc_host_model_i.pick(3'h1);
    chk("tx_oe_n", 32'h0, 32'(tx_oe_n));
    // Link disabled: the reply line is released although chosen
    wr_reg(pfcc_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clock_i);
    #1 chk("link off", 32'h1, 32'(tx_oe_n));
    wr_reg(pfcc_pkg::ADDR_CTRL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      put({1'b0, 1'b0, 1'b0, i[2:0], i[1:0]}, {1'b1, 1'b1, 1'b1, 3'h0, ~i[1:0]});
      // The reply is loaded at the end of a frame, so the second frame carries the new sensors
      pfcc_host_model_i.frame({6'h0, i[1:0]}, got);
      pfcc_host_model_i.frame({6'h0, i[1:0]}, got);
      repeat (8) @(posedge clock_i);
      #1 chk("upper level", 32'(lvl(i[1:0])), 32'(got[15:14]));
      chk("lower level", 32'(lvl(~i[1:0])), 32'(got[13:12]));
      chk("upper size", 32'(SZ_TAB[i]), 32'(got[11:9]));
      chk("answered", 32'h1, 32'(pfcc_host_model_i.answered));
      chk("feed run", 32'(i[0]), 32'(feed_run));
      chk("feed upper", 32'(i[1]), 32'(feed_up));
    end
    end_test("link");
    // Pending frame and chosen events stay masked; unmasking only the frame event raises irq
    chk("irq masked", 32'h0, 32'(irq));
    wr_reg(pfcc_pkg::ADDR_MASK, 32'h10);
    repeat (2) @(posedge clock_i);
    #1 chk("irq unmasked", 32'h1, 32'(irq));
    rd_reg(pfcc_pkg::ADDR_STATUS, rv);
    chk("status events", 32'h30, rv);
    repeat (2) @(posedge clock_i);
    #1 chk("irq after read", 32'h0, 32'(irq));
    end_test("interrupt");
    wrap_up();
  end
endmodule // pfcc_top_test
